// File: autoneg_advert_partner_regs.sv
// auto-negotiation advertisement and link partner ability registers
// assumes avalon-mm master on clock, page receiver on clock, link level from a pin
//
// Operation
// - remote fault bit applied on any restart
// - pause field applied on any restart
// - four legacy duplex bits applied on command restart
// - advertisement selector reads fixed 00001
// - partner next page bit, zero after resets
// - partner acknowledge bit, zero after resets
// - partner remote fault bit, zero after reset
// - partner pause field, reset 00
// - partner selector, 00000 until page arrives
// - completion flag set only when negotiation done
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_params.svh"

module autoneg_advert_partner_regs #(
	parameter logic [3:0] LEGACY_RESET = 4'h0,  // per product variant
	parameter int         ADDR_W       = 8
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rstn,
	// avalon-mm register port
	input  wire logic [ADDR_W-1:0]     address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [31:0]           writedata,
	input  wire logic [3:0]            byteenable,
	output var  logic [31:0]           readdata,
	output var  logic                  waitrequest,
	// link side
	input  wire logic                  link_up_pin,
	input  wire logic                  page_valid,
	input  wire autoneg_pkg::reg16_type page_word,
	// negotiation engine side
	output var  autoneg_pkg::reg16_type adv_word_tx,
	output var  logic                  an_restart_pulse,
	output var  logic                  an_complete
);
	import autoneg_pkg::*;

	an_state_type state_reg;
	reg16_type    adv_reg;
	reg16_type    partner_reg;
	logic         link_sync;
	logic         link_prev_reg;
	logic         wr_commit;
	logic         rd_commit;
	logic [31:0]  rdata_mux;
	logic [15:0]  wmask;
	logic [15:0]  wdata16;
	logic [5:0]   index;
	logic         sel_ctl;
	logic         sel_adv;
	logic         soft_reset;
	logic         cmd_restart;
	logic         loss_restart;
	logic         any_restart;
	logic         page_take;

	// link level crosses in from the pin
	bit_sync #(
		.RESET_VALUE (1'b0)
	) u_link_sync (
		.clock     (clock),
		.rstn      (rstn),
		.level_in  (link_up_pin),
		.level_out (link_sync)
	);

	mm_slave_port u_port (
		.clock       (clock),
		.rstn        (rstn),
		.read        (read),
		.write       (write),
		.readdata    (readdata),
		.waitrequest (waitrequest),
		.rdata_mux   (rdata_mux),
		.wr_commit   (wr_commit),
		.rd_commit   (rd_commit)
	);

	// decode; word index is the byte address over four
	assign index   = address[7:2];
	assign sel_ctl = (index == `AN_IDX_CONTROL);
	assign sel_adv = (index == `AN_IDX_ADVERT);
	assign wdata16 = writedata[15:0];
	assign wmask   = {{8{byteenable[1]}}, {8{byteenable[0]}}};

	// control bits are self-clearing strobes, so they need no storage
	assign soft_reset  = wr_commit && sel_ctl && wmask[`AN_CTL_SOFT_RESET] && wdata16[`AN_CTL_SOFT_RESET];
	assign cmd_restart = wr_commit && sel_ctl && wmask[`AN_CTL_RESTART] && wdata16[`AN_CTL_RESTART];
	assign loss_restart = link_prev_reg && !link_sync;
	assign any_restart = cmd_restart || loss_restart || soft_reset;
	assign page_take   = page_valid && link_sync && (state_reg == AN_BUSY);

	// previous link level for loss detection
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			link_prev_reg <= 1'b0;
		end else begin
			link_prev_reg <= link_sync;
		end
	end

	// advertisement register; top bits stored as written until a soft reset reloads bits 15:14 and clears bit 9
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			adv_reg <= {`AN_ADV_TOP_RESET, 1'b0, 1'b0, `AN_PAUSE_RESET, 1'b0, LEGACY_RESET, `AN_SELECTOR};
		end else if (soft_reset) begin
			adv_reg[15:14] <= `AN_ADV_TOP_RESET;
			adv_reg[9]     <= 1'b0;
		end else if (wr_commit && sel_adv) begin
			adv_reg[15:5] <= (adv_reg[15:5] & ~wmask[15:5]) | (wdata16[15:5] & wmask[15:5]);
			adv_reg[4:0]  <= `AN_SELECTOR;
		end
	end

	// working copy handed to negotiation; edits wait for a restart
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			adv_word_tx <= {`AN_ADV_TOP_RESET, 1'b0, 1'b0, `AN_PAUSE_RESET, 1'b0, LEGACY_RESET, `AN_SELECTOR};
		end else if (cmd_restart || soft_reset) begin
			adv_word_tx <= adv_reg;
		end else if (loss_restart) begin
			// link loss refreshes fault and pause only, duplex bits need a command
			adv_word_tx[`AN_RFAULT]                   <= adv_reg[`AN_RFAULT];
			adv_word_tx[`AN_PAUSE_HI:`AN_PAUSE_LO]    <= adv_reg[`AN_PAUSE_HI:`AN_PAUSE_LO];
		end
	end

	// restart strobe toward the negotiation engine
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			an_restart_pulse <= 1'b0;
		end else begin
			an_restart_pulse <= any_restart;
		end
	end

	// negotiation progress
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= AN_BUSY;
		end else if (any_restart) begin
			state_reg <= AN_BUSY;
		end else begin
			unique case (state_reg)
				AN_IDLE: begin
					if (link_sync) begin
						state_reg <= AN_BUSY;
					end
				end
				AN_BUSY: begin
					if (page_take) begin
						state_reg <= AN_DONE;
					end
				end
				AN_DONE: begin
					if (!link_sync) begin
						state_reg <= AN_IDLE;
					end
				end
				default: begin
					state_reg <= AN_IDLE;
				end
			endcase
		end
	end

	// completion flag, registered for the pin
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			an_complete <= 1'b0;
		end else if (any_restart || !link_sync) begin
			an_complete <= 1'b0;
		end else if (page_take) begin
			an_complete <= 1'b1;
		end
	end

	// partner ability from each accepted base page; unused bits stay zero
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			partner_reg <= `AN_PARTNER_RESET;
		end else if (soft_reset) begin
			partner_reg <= `AN_PARTNER_RESET;
		end else if (page_take) begin
			partner_reg <= `AN_PARTNER_RESET;
			partner_reg[`AN_NEXT_PAGE]             <= page_word[`AN_NEXT_PAGE];
			partner_reg[`AN_ACK]                   <= page_word[`AN_ACK];
			partner_reg[`AN_RFAULT]                <= page_word[`AN_RFAULT];
			partner_reg[`AN_PAUSE_HI:`AN_PAUSE_LO] <= page_word[`AN_PAUSE_HI:`AN_PAUSE_LO];
			partner_reg[`AN_SEL_HI:0]              <= page_word[`AN_SEL_HI:0];
		end
	end

	// read mux; unmapped words read zero
	always_comb begin
		rdata_mux = 32'h0000_0000;
		unique case (index)
			`AN_IDX_STATUS: begin
				rdata_mux[`AN_STS_COMPLETE] = an_complete;
				rdata_mux[`AN_STS_LINK]     = link_sync;
			end
			`AN_IDX_ADVERT: begin
				rdata_mux[15:0] = adv_reg;
			end
			`AN_IDX_PARTNER: begin
				rdata_mux[15:0] = partner_reg;
			end
			default: begin
				rdata_mux = 32'h0000_0000;
			end
		endcase
	end

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	a_selector_reads_fixed:
	assert property (rd_commit && sel_adv |-> readdata[4:0] == 5'h01)
		else $error("advertisement selector did not read 00001");

	a_fault_on_command:
	assert property (cmd_restart |=> adv_word_tx[13] == $past(adv_reg[13]))
		else $error("remote fault not applied on commanded restart");

	a_adv_held_idle:
	assert property (!any_restart |=> $stable(adv_word_tx))
		else $error("advertisement changed without a restart");

	a_pause_on_loss:
	assert property (loss_restart |=> adv_word_tx[11:10] == $past(adv_reg[11:10]))
		else $error("pause field not applied after link loss");

	a_legacy_kept_on_loss:
	assert property (loss_restart && !cmd_restart && !soft_reset |=> $stable(adv_word_tx[8:5]))
		else $error("duplex bits changed on link loss alone");

	a_partner_loaded:
	assert property (page_take && !soft_reset |=> partner_reg == ($past(page_word) & 16'hec1f))
		else $error("partner register not loaded from page");

	a_partner_soft_clear:
	assert property (soft_reset |=> partner_reg == 16'h0000)
		else $error("partner register not cleared by soft reset");

	a_complete_follows_page:
	assert property (page_take && !any_restart ##1 link_sync |-> an_complete)
		else $error("completion flag not set after page");

	a_complete_drops:
	// a page may legally be taken the cycle after the restart, so the second cycle allows that
	assert property (any_restart |=> !an_complete ##1 (!an_complete || $past(page_take)))
		else $error("completion flag held across restart");

	a_wait_one_cycle:
	assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("waitrequest did not drop for one cycle");

	a_restart_strobe_follows:
	assert property (any_restart |=> an_restart_pulse)
		else $error("restart strobe missing after a restart cause");

	a_restart_strobe_quiet:
	assert property (!any_restart |=> !an_restart_pulse)
		else $error("restart strobe without a restart cause");

	a_legacy_on_command:
	assert property (cmd_restart |=> adv_word_tx[8:5] == $past(adv_reg[8:5]))
		else $error("duplex bits not applied on commanded restart");

	a_pause_on_command:
	assert property (cmd_restart |=> adv_word_tx[11:10] == $past(adv_reg[11:10]))
		else $error("pause field not applied on commanded restart");

	a_fault_on_loss:
	assert property (loss_restart |=> adv_word_tx[13] == $past(adv_reg[13]))
		else $error("remote fault not applied after link loss");

	a_partner_held:
	assert property (!page_take && !soft_reset |=> $stable(partner_reg))
		else $error("partner register changed without a page");

	a_complete_tracks_state:
	assert property (an_complete == (state_reg == AN_DONE))
		else $error("completion flag disagrees with negotiation progress");

	a_partner_unused_zero:
	assert property (partner_reg[12] == 1'b0 && partner_reg[9:5] == 5'h00)
		else $error("partner register unused bits not zero");

	a_readdata_upper_zero:
	assert property (rd_commit |-> readdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");

endmodule : autoneg_advert_partner_regs

`default_nettype wire

// File: autoneg_advert_partner_regs_tb_top.sv
// bench for the advertisement and partner ability registers
// assumes a 40 MHz clock and the one-wait-state register port
`timescale 1ns/1ps
`default_nettype none

module autoneg_advert_partner_regs_tb_top;
	import autoneg_pkg::*;

	logic        clock;
	logic        rstn;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        link_up_pin;
	logic        page_valid;
	reg16_type   page_word;
	reg16_type   adv_word_tx;
	logic        an_restart_pulse;
	logic        an_complete;
	int          fail_count;
	int          total_checks;
	logic [31:0] q;

	autoneg_advert_partner_regs #(.LEGACY_RESET(4'ha), .ADDR_W(8)) dut_u (
		.clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .link_up_pin(link_up_pin), .page_valid(page_valid),
		.page_word(page_word), .adv_word_tx(adv_word_tx),
		.an_restart_pulse(an_restart_pulse), .an_complete(an_complete));

	link_partner_model partner_u (.clock(clock), .link_up_pin(link_up_pin),
		.page_valid(page_valid), .page_word(page_word));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one bus access; a spare edge first so back-to-back calls never collide
	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clock);
		address    <= a;
		read       <= ~wr;
		write      <= wr;
		writedata  <= {~d, d}; // upper half must be ignored
		byteenable <= be;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		chk(n, 2);
	endtask : bus

	// restart pulse must follow its cause within a few cycles
	task automatic see_restart(input reg16_type exp);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (an_restart_pulse !== 1'b1 && n < 10);
		chk(n < 10, 1'b1);
		chk(adv_word_tx, exp);
	endtask : see_restart

	task automatic page_then(input reg16_type w, input reg16_type exp);
		repeat (5) @(posedge clock);
		partner_u.send(w);
		@(posedge clock);
		chk(an_complete, 1'b1);
		bus(1'b0, 8'h14, 16'h0, 4'hf);
		chk(q, {16'h0, exp});
	endtask : page_then

	task automatic t_reset;
		bus(1'b0, 8'h10, 16'h0, 4'hf);
		chk(q, 32'h0000_8141);
		chk(adv_word_tx, 16'h8141);
		bus(1'b0, 8'h14, 16'h0, 4'hf);
		chk(q, 32'h0);
		bus(1'b0, 8'h3c, 16'h0, 4'hf);
		chk(q, 32'h0);
		chk(an_complete, 1'b0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_write_page;
		bus(1'b1, 8'h10, 16'hadff, 4'h3);
		bus(1'b0, 8'h12, 16'h0, 4'hf);
		chk(q, 32'h0000_ade1);
		chk(adv_word_tx, 16'h8141);
		partner_u.set_link(1'b1);
		page_then(16'hfc1f, 16'hec1f);
		bus(1'b0, 8'h04, 16'h0, 4'hf);
		chk(q[5], 1'b1);
		partner_u.send(16'h0001);
		bus(1'b0, 8'h14, 16'h0, 4'hf);
		chk(q, 32'h0000_ec1f);
		$display("test write and page done");
	endtask : t_write_page

	task automatic t_restarts;
		partner_u.set_link(1'b0);
		see_restart(16'had41);
		chk(an_complete, 1'b0);
		bus(1'b1, 8'h00, 16'h0200, 4'h3);
		see_restart(16'hade1);
		partner_u.set_link(1'b1);
		page_then(16'h2401, 16'h2401);
		$display("test restarts done");
	endtask : t_restarts

	task automatic t_soft_reset;
		bus(1'b1, 8'h10, 16'h0000, 4'h1);
		bus(1'b1, 8'h14, 16'hffff, 4'h3);
		bus(1'b0, 8'h14, 16'h0, 4'hf);
		chk(q, 32'h0000_2401);
		bus(1'b1, 8'h00, 16'h8000, 4'h3);
		see_restart(16'had01);
		bus(1'b0, 8'h10, 16'h0, 4'hf);
		chk(q, 32'h0000_ad01);
		bus(1'b0, 8'h14, 16'h0, 4'hf);
		chk(q, 32'h0);
		$display("test soft reset done");
	endtask : t_soft_reset

	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	// watchdog: whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		conclude();
	end

	initial begin
		fail_count   = 0;
		total_checks = 0;
		rstn         = 1'b0;
		address      = 8'h0;
		read         = 1'b0;
		write        = 1'b0;
		writedata    = 32'h0;
		byteenable   = 4'h0;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		t_reset();
		t_write_page();
		t_restarts();
		t_soft_reset();
		conclude();
	end
endmodule : autoneg_advert_partner_regs_tb_top
`default_nettype wire

// File: autoneg_params.svh
// offsets, field positions, reset values for the auto-negotiation register bank
// assumes a 32-bit word-aligned register bus; byte address is index times four
`ifndef AUTONEG_PARAMS_SVH
`define AUTONEG_PARAMS_SVH

// register indices (byte address = index * 4)
`define AN_IDX_CONTROL      6'h00
`define AN_IDX_STATUS       6'h01
`define AN_IDX_ADVERT       6'h04
`define AN_IDX_PARTNER      6'h05

// control register fields
`define AN_CTL_SOFT_RESET   15
`define AN_CTL_RESTART      9

// status register fields
`define AN_STS_COMPLETE     5
`define AN_STS_LINK         2

// advertisement / partner ability fields
`define AN_NEXT_PAGE        15
`define AN_ACK              14
`define AN_RFAULT           13
`define AN_PAUSE_HI         11
`define AN_PAUSE_LO         10
`define AN_LEGACY_HI        8
`define AN_LEGACY_LO        5
`define AN_SEL_HI           4

// reset values
`define AN_ADV_TOP_RESET    2'h2
`define AN_PAUSE_RESET      2'h0
`define AN_SELECTOR         5'h01
`define AN_PARTNER_RESET    16'h0000

`endif

// File: autoneg_pkg.sv
// types shared by the auto-negotiation register bank
// assumes nothing beyond a SystemVerilog compiler
package autoneg_pkg;

	// negotiation progress
	typedef enum logic [1:0] {
		AN_IDLE = 2'b00,
		AN_BUSY = 2'b01,
		AN_DONE = 2'b10
	} an_state_type;

	typedef logic [15:0] reg16_type;

endpackage : autoneg_pkg

// File: bit_sync.sv
// two-flop synchroniser for a level arriving from a pin
// assumes the level is slow compared with the clock
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rstn,
	// level in and out
	input  wire logic level_in,
	output var  logic level_out
);

	logic meta_reg;

	// first flop feeds only the second
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_reg  <= RESET_VALUE;
			level_out <= RESET_VALUE;
		end else begin
			meta_reg  <= level_in;
			level_out <= meta_reg;
		end
	end

endmodule : bit_sync

`default_nettype wire

// File: link_partner_model.sv
// remote link partner: drives the link level and base pages
// assumes the bench calls its tasks from the register clock domain
`timescale 1ns/1ps
`default_nettype none

module link_partner_model (
	// clock
	input  wire logic                   clock,
	// line side
	output var  logic                   link_up_pin,
	output var  logic                   page_valid,
	output var  autoneg_pkg::reg16_type page_word
);
	import autoneg_pkg::*;

	initial begin
		link_up_pin = 1'b0;
		page_valid  = 1'b0;
		page_word   = 16'h5555;
	end

	// link level changes just after an edge
	task automatic set_link(input logic v);
		@(posedge clock);
		link_up_pin <= v;
	endtask : set_link

	// one-cycle base page; the word is scrambled once released
	task automatic send(input reg16_type w);
		@(posedge clock);
		page_valid <= 1'b1;
		page_word  <= w;
		@(posedge clock);
		page_valid <= 1'b0;
		page_word  <= ~w;
	endtask : send
endmodule : link_partner_model
`default_nettype wire

// File: mm_slave_port.sv
// avalon-mm slave handshake: one wait state, registered read data
// assumes the master holds its request until it sees waitrequest low
`timescale 1ns/1ps
`default_nettype none

module mm_slave_port (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// bus side
	input  wire logic        read,
	input  wire logic        write,
	output var  logic [31:0] readdata,
	output var  logic        waitrequest,
	// register side
	input  wire logic [31:0] rdata_mux,
	output var  logic        wr_commit,
	output var  logic        rd_commit
);

	// waitrequest drops for exactly the cycle ending at the accepting edge
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// data captured one edge early so it stands at the accepting edge
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			readdata <= 32'h0000_0000;
		end else if (read && waitrequest) begin
			readdata <= rdata_mux;
		end
	end

	assign wr_commit = write && !waitrequest;
	assign rd_commit = read && !waitrequest;

endmodule : mm_slave_port

`default_nettype wire
